// >>> hw/iprh_pkg.sv
// Shared constants and types of the inventory page read handler.
package iprh_pkg;

    // **************************************************************
    // Command and response codes
    // **************************************************************
    localparam logic [7:0]  IPRH_CMD_PAGE_READ = 8'hb0;
    localparam logic [7:0]  IPRH_RSP_FLAGS     = 8'h00;
    localparam logic [7:0]  IPRH_STAT_OPEN     = 8'h00;
    localparam logic [7:0]  IPRH_STAT_LOCKED   = 8'h0f;
    // Manufacturer code of this tag; the value is arbitrary.
    localparam logic [7:0]  IPRH_MFG_CODE      = 8'h5a;
    localparam logic [7:0]  IPRH_AFI_ANY       = 8'h00;

    // **************************************************************
    // Request flag bit positions (bit 0 is the first flag)
    // **************************************************************
    localparam int          IPRH_FLG_INV       = 2;
    localparam int          IPRH_FLG_AFI       = 4;
    localparam int          IPRH_FLG_ONE_SLOT  = 5;
    localparam int          IPRH_FLG_OPT       = 6;

    // **************************************************************
    // Memory and identifier geometry
    // **************************************************************
    localparam int          IPRH_NUM_PAGES     = 20;
    localparam logic [7:0]  IPRH_LAST_PAGE     = 8'h13;
    localparam logic [3:0]  IPRH_LAST_BYTE     = 4'hf;
    localparam int          IPRH_ADDR_W        = 9;
    localparam logic [7:0]  IPRH_UID_BITS_ONE  = 8'h40;
    localparam logic [7:0]  IPRH_UID_BITS_16   = 8'h3c;
    localparam logic [3:0]  IPRH_UID_BYTES     = 4'h8;

    // **************************************************************
    // CRC of the frame
    // **************************************************************
    localparam logic [15:0] IPRH_CRC_INIT      = 16'hffff;
    localparam logic [15:0] IPRH_CRC_POLY      = 16'h8408;
    localparam logic [15:0] IPRH_CRC_RESIDUE   = 16'hf0b8;

    typedef enum {
        R_FLAGS, R_CMD, R_MFG, R_AFI, R_MLEN, R_MASK,
        R_FIRST, R_CNT, R_CRC1, R_CRC2, R_DONE, R_SKIP
    } iprh_rx_t;

    typedef enum {
        S_IDLE, S_WAIT, S_FLAGS, S_UID, S_STAT, S_DATA, S_CRC_LO, S_CRC_HI
    } iprh_st_t;

endpackage : iprh_pkg

// >>> hw/iprh_crc.sv
// One byte step of the reflected 16-bit frame CRC.
`timescale 1ns/1ps
module iprh_crc
    import iprh_pkg::*;
(
    // CRC state in and out, and the data byte
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_out
);

    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ IPRH_CRC_POLY) : (c >> 1);
        end
        crc_out = c;
    end

endmodule : iprh_crc

// >>> hw/iprh_page_mem.sv
// User page memory, one byte wide, with registered read data.
`timescale 1ns/1ps
module iprh_page_mem
    import iprh_pkg::*;
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // Write port
    input  wire logic                   wr_en,
    input  wire logic [IPRH_ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]             wr_data,
    // Read port
    input  wire logic [IPRH_ADDR_W-1:0] rd_addr,
    output logic      [7:0]             rd_data
);

    logic [7:0] mem [IPRH_NUM_PAGES*16];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : iprh_page_mem

// >>> hw/iprh_handler.sv
// Inventory page read handler: parses the request and streams the answer.
`timescale 1ns/1ps
module iprh_handler
    import iprh_pkg::*;
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    // Decoded request bytes from the receiver
    input  wire logic                      rx_valid,
    input  wire logic [7:0]                rx_byte,
    input  wire logic                      rx_end,
    input  wire logic                      rx_err,
    input  wire logic                      slot_eof,
    // Response bytes to the transmitter
    output logic                           tx_valid,
    output logic      [7:0]                tx_data,
    output logic                           tx_last,
    input  wire logic                      tx_ready,
    // Tag identity and protection
    input  wire logic [63:0]               uid,
    input  wire logic [7:0]                afi,
    input  wire logic [IPRH_NUM_PAGES-1:0] page_rd_prot,
    input  wire logic                      pwd_accept,
    output logic                           rd_pwd_ok,
    // Memory load port
    input  wire logic                      mem_wr_en,
    input  wire logic [IPRH_ADDR_W-1:0]    mem_wr_addr,
    input  wire logic [7:0]                mem_wr_data
);

    // **************************************************************
    // Declarations
    // **************************************************************
    iprh_rx_t               rx_st;
    iprh_st_t               st;
    logic [7:0]             flags;
    logic [7:0]             mlen;
    logic [63:0]            mask;
    logic [3:0]             mask_cnt;
    logic [7:0]             first_pg;
    logic [7:0]             cnt_pg;
    logic                   bad;
    logic [15:0]            crc;
    logic [15:0]            next_crc;
    logic [7:0]             crc_byte;
    logic [3:0]             slot_cnt;
    logic [7:0]             page;
    logic [3:0]             byte_idx;
    logic [3:0]             uid_idx;
    logic                   pend;
    logic [7:0]             mem_rdata;
    logic [IPRH_ADDR_W-1:0] mem_raddr;
    logic                   emit;
    logic [7:0]             next_byte;
    logic                   free;
    logic                   rx_en;
    logic                   one_slot;
    logic [7:0]             mlen_max;
    logic [3:0]             mask_bytes;
    logic [63:0]            uid_sh;
    logic [3:0]             slot_tgt;
    logic [3:0]             uid_nb;
    logic [8:0]             pg_sum;
    logic [7:0]             last_pg;
    logic                   mask_hit;
    logic                   req_ok;
    logic                   start;

    // True when the page's data must be withheld.
    function automatic logic page_locked(input logic [7:0] pg,
                                         input logic [IPRH_NUM_PAGES-1:0] prot,
                                         input logic pwd_ok);
        page_locked = prot[pg[4:0]] && !pwd_ok;
    endfunction : page_locked

    // **************************************************************
    // Request decode
    // **************************************************************
    assign rx_en      = (st == S_IDLE) || (st == S_WAIT);
    assign one_slot   = flags[IPRH_FLG_ONE_SLOT];
    assign mlen_max   = one_slot ? IPRH_UID_BITS_ONE : IPRH_UID_BITS_16;
    assign mask_bytes = 4'((mlen + 8'd7) >> 3);
    assign uid_sh     = uid >> mlen[6:0];
    assign slot_tgt   = uid_sh[3:0];
    assign uid_nb     = 4'((8'(mlen_max - mlen) + 8'd7) >> 3);
    assign pg_sum     = {1'b0, first_pg} + {1'b0, cnt_pg};
    assign last_pg    = (pg_sum > {1'b0, IPRH_LAST_PAGE}) ? IPRH_LAST_PAGE
                                                          : pg_sum[7:0];
    assign mask_hit   = ((uid ^ mask) & ((64'h1 << mlen[6:0]) - 64'h1)) == 64'h0;
    assign req_ok     = (rx_st == R_DONE) && !bad && !rx_err
                        && (crc == IPRH_CRC_RESIDUE)
                        && flags[IPRH_FLG_INV]
                        && mask_hit && (first_pg <= IPRH_LAST_PAGE);
    assign start      = (st == S_IDLE) && rx_end && req_ok;

    // Field walk of the request; an unknown command is skipped silently.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_st    <= R_FLAGS;
            flags    <= 8'h00;
            mlen     <= 8'h00;
            mask     <= 64'h0;
            mask_cnt <= 4'h0;
            first_pg <= 8'h00;
            cnt_pg   <= 8'h00;
            bad      <= 1'b0;
        end else if (rx_end) begin
            rx_st <= R_FLAGS;
            bad   <= 1'b0;
        end else if (rx_valid && rx_en) begin
            unique case (rx_st)
                R_FLAGS: begin
                    flags <= rx_byte;
                    rx_st <= R_CMD;
                end
                R_CMD: begin
                    rx_st <= (rx_byte == IPRH_CMD_PAGE_READ) ? R_MFG : R_SKIP;
                end
                R_MFG: begin
                    bad   <= bad || (rx_byte != IPRH_MFG_CODE);
                    rx_st <= flags[IPRH_FLG_AFI] ? R_AFI : R_MLEN;
                end
                R_AFI: begin
                    bad   <= bad || ((rx_byte != IPRH_AFI_ANY) && (rx_byte != afi));
                    rx_st <= R_MLEN;
                end
                R_MLEN: begin
                    mlen     <= rx_byte;
                    mask     <= 64'h0;
                    mask_cnt <= 4'h0;
                    bad      <= bad || (rx_byte > mlen_max);
                    rx_st    <= (rx_byte == 8'h00) ? R_FIRST : R_MASK;
                end
                R_MASK: begin
                    mask[{mask_cnt[2:0], 3'b000} +: 8] <= rx_byte;
                    mask_cnt <= mask_cnt + 4'h1;
                    if (mask_cnt + 4'h1 == mask_bytes) begin
                        rx_st <= R_FIRST;
                    end
                end
                R_FIRST: begin
                    first_pg <= rx_byte;
                    rx_st    <= R_CNT;
                end
                R_CNT: begin
                    cnt_pg <= rx_byte;
                    rx_st  <= R_CRC1;
                end
                R_CRC1: rx_st <= R_CRC2;
                R_CRC2: rx_st <= R_DONE;
                R_DONE: bad   <= 1'b1;
                R_SKIP: rx_st <= R_SKIP;
            endcase
        end
    end

    // **************************************************************
    // Shared CRC: checks the request, then builds the response CRC
    // **************************************************************
    assign crc_byte = rx_en ? rx_byte : next_byte;

    iprh_crc u_crc (
        .crc_in  (crc),
        .data    (crc_byte),
        .crc_out (next_crc)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            crc <= IPRH_CRC_INIT;
        end else if (rx_end || start || (st == S_WAIT && slot_eof)
                     || (st == S_CRC_HI && emit)) begin
            crc <= IPRH_CRC_INIT;
        end else if (rx_en && rx_valid) begin
            crc <= next_crc;
        end else if (emit && st != S_CRC_LO && st != S_CRC_HI) begin
            crc <= next_crc;
        end
    end

    // **************************************************************
    // Session password flag
    // **************************************************************
    // Only a power-on reset clears it, so it lives for the whole field session.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_pwd_ok <= 1'b0;
        end else if (pwd_accept) begin
            rd_pwd_ok <= 1'b1;
        end
    end

    // **************************************************************
    // Response byte source
    // **************************************************************
    assign free      = !tx_valid || tx_ready;
    assign mem_raddr = IPRH_ADDR_W'({page, 4'h0} + {8'h00, byte_idx});

    iprh_page_mem u_mem (
        .clock   (clock),
        .rst_b   (rst_b),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (mem_wr_data),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    always_comb begin
        emit      = 1'b0;
        next_byte = 8'h00;
        unique case (st)
            S_FLAGS: begin
                emit      = free;
                next_byte = IPRH_RSP_FLAGS;
            end
            S_UID: begin
                emit      = free;
                next_byte = uid[{uid_idx[2:0], 3'b000} +: 8];
            end
            S_STAT: begin
                emit      = free;
                next_byte = page_locked(page, page_rd_prot, rd_pwd_ok)
                            ? IPRH_STAT_LOCKED : IPRH_STAT_OPEN;
            end
            S_DATA: begin
                emit      = free && pend;
                next_byte = mem_rdata;
            end
            S_CRC_LO: begin
                emit      = free;
                next_byte = ~crc[7:0];
            end
            S_CRC_HI: begin
                emit      = free;
                next_byte = ~crc[15:8];
            end
            default: begin
                emit      = 1'b0;
                next_byte = 8'h00;
            end
        endcase
    end

    // **************************************************************
    // Sequencer
    // **************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st       <= S_IDLE;
            slot_cnt <= 4'h0;
            page     <= 8'h00;
            byte_idx <= 4'h0;
            uid_idx  <= 4'h0;
            pend     <= 1'b0;
        end else begin
            unique case (st)
                S_IDLE: begin
                    slot_cnt <= 4'h0;
                    if (start) begin
                        st <= (one_slot || slot_tgt == 4'h0) ? S_FLAGS : S_WAIT;
                    end
                end
                S_WAIT: begin
                    // A fresh request from the reader ends this round.
                    if (rx_valid) begin
                        st <= S_IDLE;
                    end else if (slot_eof) begin
                        slot_cnt <= slot_cnt + 4'h1;
                        if (slot_cnt + 4'h1 == slot_tgt) begin
                            st <= S_FLAGS;
                        end
                    end
                end
                S_FLAGS: begin
                    page    <= first_pg;
                    uid_idx <= IPRH_UID_BYTES - uid_nb;
                    if (emit) begin
                        st <= (flags[IPRH_FLG_OPT] && uid_nb != 4'h0) ? S_UID
                                                                      : S_STAT;
                    end
                end
                S_UID: begin
                    if (emit) begin
                        uid_idx <= uid_idx + 4'h1;
                        if (uid_idx == IPRH_UID_BYTES - 4'h1) begin
                            st <= S_STAT;
                        end
                    end
                end
                S_STAT: begin
                    byte_idx <= 4'h0;
                    pend     <= 1'b0;
                    if (emit) begin
                        if (!page_locked(page, page_rd_prot, rd_pwd_ok)) begin
                            st <= S_DATA;
                        end else if (page == last_pg) begin
                            st <= S_CRC_LO;
                        end else begin
                            page <= page + 8'h01;
                        end
                    end
                end
                S_DATA: begin
                    // The memory answers one cycle after the address settles.
                    if (!pend) begin
                        pend <= 1'b1;
                    end else if (emit) begin
                        pend     <= 1'b0;
                        byte_idx <= byte_idx + 4'h1;
                        if (byte_idx == IPRH_LAST_BYTE) begin
                            if (page == last_pg) begin
                                st <= S_CRC_LO;
                            end else begin
                                page <= page + 8'h01;
                                st   <= S_STAT;
                            end
                        end
                    end
                end
                S_CRC_LO: begin
                    if (emit) begin
                        st <= S_CRC_HI;
                    end
                end
                S_CRC_HI: begin
                    if (emit) begin
                        st <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Output byte holder.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
        end else if (emit) begin
            tx_valid <= 1'b1;
            tx_data  <= next_byte;
            tx_last  <= (st == S_CRC_HI);
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
        end
    end

    // **************************************************************
    // Assertions
    // **************************************************************
    property p_cmd;
        @(posedge clock) disable iff (!rst_b)
        (rx_valid && rx_en && rx_st == R_CMD && rx_byte != IPRH_CMD_PAGE_READ)
            |=> (rx_st == R_SKIP);
    endproperty
    a_cmd: assert property (p_cmd) else $error("foreign command not skipped");

    property p_silent;
        @(posedge clock) disable iff (!rst_b)
        (st == S_IDLE && rx_end && !req_ok) |=> (st == S_IDLE) [*2] ##0 !tx_valid;
    endproperty
    a_silent: assert property (p_silent) else $error("answer to bad request");

    property p_flags_byte;
        @(posedge clock) disable iff (!rst_b)
        (st == S_FLAGS && emit) |=> (tx_valid && tx_data == IPRH_RSP_FLAGS);
    endproperty
    a_flags_byte: assert property (p_flags_byte) else $error("bad flags byte");

    property p_no_uid;
        @(posedge clock) disable iff (!rst_b)
        (st == S_UID) |-> flags[IPRH_FLG_OPT];
    endproperty
    a_no_uid: assert property (p_no_uid) else $error("identifier sent without option");

    property p_open;
        @(posedge clock) disable iff (!rst_b)
        (st == S_STAT && emit && !page_locked(page, page_rd_prot, rd_pwd_ok))
            |=> (tx_data == IPRH_STAT_OPEN) ##0 (st == S_DATA);
    endproperty
    a_open: assert property (p_open) else $error("open page status wrong");

    property p_locked;
        @(posedge clock) disable iff (!rst_b)
        (st == S_STAT && emit && page_locked(page, page_rd_prot, rd_pwd_ok))
            |=> (tx_data == IPRH_STAT_LOCKED) ##0 (st != S_DATA);
    endproperty
    a_locked: assert property (p_locked) else $error("locked page status wrong");

    property p_page_bound;
        @(posedge clock) disable iff (!rst_b)
        (st == S_DATA || st == S_STAT) |-> (page <= last_pg && page <= IPRH_LAST_PAGE);
    endproperty
    a_page_bound: assert property (p_page_bound) else $error("page past end");

    property p_slot;
        @(posedge clock) disable iff (!rst_b)
        (st == S_WAIT && slot_eof && !rx_valid && slot_cnt + 4'h1 == slot_tgt)
            |=> (st == S_FLAGS);
    endproperty
    a_slot: assert property (p_slot) else $error("missed own slot");

    property p_uid_count;
        @(posedge clock) disable iff (!rst_b)
        $rose(st == S_UID) |-> (uid_idx == IPRH_UID_BYTES - uid_nb);
    endproperty
    a_uid_count: assert property (p_uid_count) else $error("identifier length wrong");

    property p_pwd;
        @(posedge clock) disable iff (!rst_b)
        pwd_accept |=> rd_pwd_ok [*3];
    endproperty
    a_pwd: assert property (p_pwd) else $error("password flag lost");

    c_one_slot: cover property (@(posedge clock) disable iff (!rst_b)
        start && one_slot);
    c_slot_wait: cover property (@(posedge clock) disable iff (!rst_b)
        st == S_WAIT ##1 st == S_FLAGS);
    c_locked: cover property (@(posedge clock) disable iff (!rst_b)
        st == S_STAT && emit && page_locked(page, page_rd_prot, rd_pwd_ok));
    c_end: cover property (@(posedge clock) disable iff (!rst_b)
        tx_valid && tx_last && tx_ready);

endmodule : iprh_handler

// >>> verification/iprh_reader.sv
// Reader model: sends request frames and takes the answer bytes.
`timescale 1ns/1ps
module iprh_reader (
    // Request side
    input  wire logic       clock,
    output logic            rx_valid,
    output logic      [7:0] rx_byte,
    output logic            rx_end,
    output logic            rx_err,
    // Answer side
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last
);
    logic [7:0] rsp[$];
    initial {rx_valid, rx_byte, rx_end, rx_err, tx_ready} = '0;
    // Bytes go back to back; the data lines are scrambled once released.
    task automatic send(input logic [7:0] f[$], input logic err);
        foreach (f[i]) begin
            @(posedge clock) #1 rx_valid = 1'b1;
            rx_byte = f[i];
        end
        @(posedge clock) #1 {rx_valid, rx_end, rx_err} = {2'b01, err};
        rx_byte = ~rx_byte;
        @(posedge clock) #1 {rx_end, rx_err} = 2'b00;
    endtask : send
    // Ready toggles every cycle, so the answer is stalled half the time.
    task automatic collect(output int n);
        rsp = {};
        for (n = 0; n < 400; n++) begin
            @(posedge clock);
            if (tx_valid === 1'b1 && tx_ready) rsp.push_back(tx_data);
            if (tx_valid === 1'b1 && tx_ready && tx_last === 1'b1) break;
            #1 tx_ready = ~tx_ready;
        end
        #1 tx_ready = 1'b0;
    endtask : collect
endmodule : iprh_reader

// >>> verification/testbench.sv
// Bench for the page read handler: request frames in, answers compared.
`timescale 1ns/1ps
module testbench;
    import iprh_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic rx_valid, rx_end, rx_err, tx_ready, tx_valid, tx_last, slot_eof, pwd_accept;
    logic rd_pwd_ok, mem_wr_en, pwd;
    logic [7:0] rx_byte, tx_data, afi, mem_wr_data;
    logic [63:0] uid;
    logic [19:0] page_rd_prot;
    logic [8:0] mem_wr_addr;
    int n_errors = 0;
    int checks = 0;
    always #5 clock = ~clock;
    iprh_handler i_iprh_handler (.clock, .rst_b, .rx_valid, .rx_byte, .rx_end, .rx_err,
        .slot_eof, .tx_valid, .tx_data, .tx_last, .tx_ready, .uid, .afi, .page_rd_prot,
        .pwd_accept, .rd_pwd_ok, .mem_wr_en, .mem_wr_addr, .mem_wr_data);
    iprh_reader i_iprh_reader (.clock, .rx_valid, .rx_byte, .rx_end, .rx_err, .tx_ready,
        .tx_valid, .tx_data, .tx_last);
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = IPRH_CRC_INIT;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ IPRH_CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction : crc
    task automatic give_verdict;
        $display("Checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    // One request and its answer; bad[0] spoils the CRC, bad[1] flags a coding error.
    // Slots is the number of slot ends the reader gives before the answer is due.
    task automatic run(input logic [7:0] flg, ml, first, cnt, input logic [1:0] bad,
                       input int slots = 0);
        logic [7:0] rq[$], ex[$];
        logic [15:0] c;
        int n, nb, last;
        rq = {flg, IPRH_CMD_PAGE_READ, IPRH_MFG_CODE, ml};
        for (int i = 0; i < (ml + 7) / 8; i++) rq.push_back(uid[8*i +: 8]);
        rq.push_back(first);
        rq.push_back(cnt);
        c = crc(rq) ^ {15'h0, bad[0]};
        rq.push_back(c[7:0]);
        rq.push_back(c[15:8]);
        ex = {IPRH_RSP_FLAGS};
        nb = ((flg[IPRH_FLG_ONE_SLOT] ? 64 : 60) - ml + 7) / 8;
        if (flg[IPRH_FLG_OPT]) for (int i = 8 - nb; i < 8; i++) ex.push_back(uid[8*i +: 8]);
        last = (first + cnt > 19) ? 19 : first + cnt;
        for (int p = first; p <= last; p++) begin
            ex.push_back((page_rd_prot[p] && !pwd) ? IPRH_STAT_LOCKED : IPRH_STAT_OPEN);
            if (ex[$] == IPRH_STAT_OPEN) for (int b = 0; b < 16; b++) ex.push_back(8'(p*16+b) ^ 8'h3c);
        end
        c = crc(ex);
        ex.push_back(c[7:0]);
        ex.push_back(c[15:8]);
        if (bad != 2'b00 || !flg[IPRH_FLG_INV]) ex = {};
        i_iprh_reader.send(rq, bad[1]);
        repeat (slots) begin
            @(posedge clock) #1 slot_eof = 1'b1;
            check("early answer", 16'h0, {15'h0, tx_valid});
            @(posedge clock) #1 slot_eof = 1'b0;
        end
        i_iprh_reader.collect(n);
        check("length", 16'(ex.size()), 16'(i_iprh_reader.rsp.size()));
        if (ex.size() == i_iprh_reader.rsp.size())
            foreach (ex[i]) check("byte", 16'(ex[i]), 16'(i_iprh_reader.rsp[i]));
        if (ex.size() > 0 && n >= 400) begin
            n_errors++;
            $display("Error answer end expected %0d cycles seen %0d", 400, n);
            give_verdict();
        end
    endtask : run
    initial begin
        {slot_eof, pwd_accept, pwd, mem_wr_en, mem_wr_addr, mem_wr_data} = '0;
        afi = 8'h00;
        uid = 64'h8a7e_13c5_9d24_6b00;
        page_rd_prot = 20'h80001;
        repeat (12) @(posedge clock);
        #1 rst_b = 1'b1;
        check("session flag", 16'h0, {15'h0, rd_pwd_ok});
        for (int a = 0; a < 320; a++) begin
            {mem_wr_en, mem_wr_addr, mem_wr_data} = {1'b1, 9'(a), 8'(a) ^ 8'h3c};
            @(posedge clock) #1;
        end
        mem_wr_en = 1'b0;
        run(8'h24, 8'h00, 8'h12, 8'h03, 2'b00);
        run(8'h64, 8'h08, 8'h00, 8'h01, 2'b00);
        run(8'h44, 8'h00, 8'h02, 8'h00, 2'b00);
        run(8'h04, 8'h08, 8'h03, 8'h00, 2'b00, 11);
        run(8'h24, 8'h00, 8'h00, 8'h00, 2'b01);
        run(8'h24, 8'h00, 8'h00, 8'h00, 2'b10);
        run(8'h20, 8'h00, 8'h00, 8'h00, 2'b00);
        {pwd_accept, pwd} = 2'b11;
        @(posedge clock) #1 pwd_accept = 1'b0;
        run(8'h24, 8'h00, 8'h13, 8'h00, 2'b00);
        check("session flag", 16'h1, {15'h0, rd_pwd_ok});
        give_verdict();
    end
endmodule : testbench
